// ### rtl/acr_pkg.sv
package acr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DATA_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_X_HIGH        = 8'h01;
  localparam logic [7:0] ADDR_X_LOW         = 8'h02;
  localparam logic [7:0] ADDR_Y_HIGH        = 8'h03;
  localparam logic [7:0] ADDR_Y_LOW         = 8'h04;
  localparam logic [7:0] ADDR_Z_HIGH        = 8'h05;
  localparam logic [7:0] ADDR_Z_LOW         = 8'h06;
  localparam logic [7:0] ADDR_SYS_MODE      = 8'h0b;
  localparam logic [7:0] ADDR_EVENT_SOURCE  = 8'h0c;
  localparam logic [7:0] ADDR_IDENTITY      = 8'h0d;
  localparam logic [7:0] ADDR_RANGE_CFG     = 8'h0e;
  localparam logic [7:0] ADDR_ORIENT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ORIENT_CFG    = 8'h11;
  localparam logic [7:0] ADDR_ORIENT_DBNC   = 8'h12;
  localparam logic [7:0] ADDR_BF_COMP       = 8'h13;
  localparam logic [7:0] ADDR_TRIP_ANGLE    = 8'h14;
  localparam logic [7:0] ADDR_MOTION_CFG    = 8'h15;
  localparam logic [7:0] ADDR_MOTION_SOURCE = 8'h16;
  localparam logic [7:0] ADDR_MOTION_THS    = 8'h17;
  localparam logic [7:0] ADDR_MOTION_DBNC   = 8'h18;
  localparam logic [7:0] ADDR_SLEEP_COUNT   = 8'h29;
  localparam logic [7:0] ADDR_CTRL_ONE      = 8'h2a;
  localparam logic [7:0] ADDR_CTRL_TWO      = 8'h2b;
  localparam logic [7:0] ADDR_CTRL_THREE    = 8'h2c;
  localparam logic [7:0] ADDR_CTRL_FOUR     = 8'h2d;
  localparam logic [7:0] ADDR_CTRL_FIVE     = 8'h2e;
  localparam logic [7:0] ADDR_X_OFFSET      = 8'h2f;
  localparam logic [7:0] ADDR_Y_OFFSET      = 8'h30;
  localparam logic [7:0] ADDR_Z_OFFSET      = 8'h31;

  // Reset values that are not zero, then zero itself
  localparam logic [7:0] RST_ORIENT_CFG = 8'h80;
  localparam logic [7:0] RST_BF_COMP    = 8'h44;
  localparam logic [7:0] RST_TRIP_ANGLE = 8'h84;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  // Field positions
  localparam int CTRL1_ACTIVE_BIT    = 0;
  localparam int CTRL1_FAST_READ_BIT = 1;
  localparam int CTRL2_SOFT_RST_BIT  = 6;

  // Two-wire bus and sample format
  localparam logic [6:0] DEV_ADDR   = 7'h1d;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam int         SAMPLE_W   = 10;
  localparam logic [5:0] LOW_PAD    = 6'h00;

  // System mode codes
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE    = 2'h1;
  localparam logic [1:0] MODE_SLEEP   = 2'h2;

  typedef struct packed {
    logic [SAMPLE_W-1:0] x;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] z;
  } acr_sample_t;

  typedef struct packed {
    logic [7:0] data_status;
    logic [7:0] event_source;
    logic [7:0] orientation_status;
    logic [7:0] motion_source;
  } acr_stat_t;

  typedef struct packed {
    logic [7:0] range_config;
    logic [7:0] orientation_config;
    logic [7:0] orientation_debounce;
    logic [7:0] motion_detect_config;
    logic [7:0] motion_detect_threshold;
    logic [7:0] motion_detect_debounce;
    logic [7:0] sleep_wake_counter;
    logic [7:0] control_one_rate_mode;
    logic [7:0] control_two_sleep_reset;
    logic [7:0] control_three_wake_pin;
    logic [7:0] control_four_irq_enable;
    logic [7:0] control_five_irq_route;
    logic [7:0] x_offset_adjust;
    logic [7:0] y_offset_adjust;
    logic [7:0] z_offset_adjust;
  } acr_cfg_t;

  localparam acr_cfg_t CFG_RESET = '{orientation_config: RST_ORIENT_CFG, default: RST_ZERO};

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_ADDR   = 9'h002,
    ST_ACK_AD = 9'h004,
    ST_REG    = 9'h008,
    ST_ACK_RG = 9'h010,
    ST_WDATA  = 9'h020,
    ST_ACK_WR = 9'h040,
    ST_RDATA  = 9'h080,
    ST_RACK   = 9'h100
  } acr_state_t;

endpackage : acr_pkg

// ### rtl/acr_sync2.sv
`timescale 1ns/1ps
module acr_sync2 #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // Idle bus is high, so both stages reset high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= '1;
      sync_o <= '1;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : acr_sync2

// ### rtl/acr_ptr_step.sv
`timescale 1ns/1ps
module acr_ptr_step (
  // Pointer
  input  wire logic [7:0] ptr_i,
  input  wire logic       fast_read_i,
  output logic      [7:0] next_o
);

  function automatic logic [7:0] step(input logic [7:0] p, input logic fr);
    logic [7:0] n;
    n = p + 8'h01;
    case (p)
      acr_pkg::ADDR_X_HIGH: n = fr ? acr_pkg::ADDR_Y_HIGH : acr_pkg::ADDR_X_LOW; // [RL1] [RL2]
      acr_pkg::ADDR_X_LOW:  n = fr ? acr_pkg::ADDR_DATA_STATUS : acr_pkg::ADDR_Y_HIGH; // [RL1]
      acr_pkg::ADDR_Y_HIGH: n = fr ? acr_pkg::ADDR_Z_HIGH : acr_pkg::ADDR_Y_LOW; // [RL2]
      acr_pkg::ADDR_Y_LOW:  n = fr ? acr_pkg::ADDR_DATA_STATUS : acr_pkg::ADDR_Z_HIGH;
      acr_pkg::ADDR_Z_HIGH: n = fr ? acr_pkg::ADDR_DATA_STATUS : acr_pkg::ADDR_Z_LOW; // [RL2]
      acr_pkg::ADDR_Z_LOW:  n = acr_pkg::ADDR_DATA_STATUS; // [RL1]
      acr_pkg::ADDR_Z_OFFSET: n = acr_pkg::ADDR_IDENTITY; // [RL5]
      default: n = p + 8'h01; // [RL5]
    endcase
    return n;
  endfunction : step

  assign next_o = step(ptr_i, fast_read_i); // [RL13]

endmodule : acr_ptr_step

// ### rtl/acr_regbank.sv
// Functional notes
// [RL1] Without fast-read, burst pointer walks 0x01..0x06, then wraps to 0x00.
// [RL2] With fast-read, pointer skips low bytes: 0x01->0x03->0x05->0x00.
// [RL3] Ten-bit sample: high byte bits 9..2, low byte bits 1..0 in 7..6.
// [RL4] Reserved addresses read as zero.
// [RL5] Elsewhere pointer steps by one; after 0x31 it wraps to 0x0d.
// [RL6] Sample and status content is meaningful only in active mode.
// [RL7] Standby to active clears data, event, orientation and motion status.
// [RL8] Configuration and identity survive the move from active to standby.
// [RL9] Config writes act only in standby, except active bit and soft reset.
// [RL10] Reset reads zero except 0x0d=identity, 0x11=0x80, 0x13=0x44, 0x14=0x84.
// [RL11] Bus address 0011101; eighth bit one means read, zero write.
// [RL12] Pointer advances after each byte; master ends reads with nack, stop.
// [RL13] Fast-read bit in control one selects eight-bit sample access.
// [RL14] Writes to read-only or reserved addresses are acked and change nothing.
`timescale 1ns/1ps
module acr_regbank #(
  // Arbitrary value, not tied to any part
  parameter logic [7:0] IDENTITY_VALUE = 8'h3c,
  parameter logic [6:0] BUS_ADDR       = acr_pkg::DEV_ADDR
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Two-wire bus pins
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  // Sensing core side
  input  wire acr_pkg::acr_sample_t sample_i,
  input  wire logic               sample_load_i,
  input  wire acr_pkg::acr_stat_t stat_i,
  input  wire logic               stat_load_i,
  input  wire logic               sleep_i,
  // Configuration to the core
  output acr_pkg::acr_cfg_t       cfg_o,
  output logic                    active_o,
  output logic                    fast_read_o,
  output logic                    soft_reset_o
);

  generate
    if (BUS_ADDR == 7'h00)
    begin : g_bad_addr
      $error("Bus address zero is the general call and cannot be used");
    end
  endgenerate

  // Pin synchronisers
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;

  acr_sync2 #(
    .W (2)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .async_i ({scl_i, sda_i}),
    .sync_o  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // Bus engine state
  acr_pkg::acr_state_t st_q;
  acr_pkg::acr_state_t st_d;
  logic [3:0]          cnt_q;
  logic [3:0]          cnt_d;
  logic [7:0]          sr_q;
  logic [7:0]          sr_d;
  logic [7:0]          tx_q;
  logic [7:0]          tx_d;
  logic [7:0]          ptr_q;
  logic [7:0]          ptr_d;
  logic                rw_q;
  logic                rw_d;
  logic                oe_n_q;
  logic                oe_n_d;

  // Register contents
  acr_pkg::acr_cfg_t    cfg_q;
  acr_pkg::acr_cfg_t    cfg_d;
  acr_pkg::acr_sample_t smp_q;
  acr_pkg::acr_stat_t   stat_q;
  logic                 active_prev_q;
  logic                 soft_rst_q;

  wire active    = cfg_q.control_one_rate_mode[acr_pkg::CTRL1_ACTIVE_BIT];
  wire fast_read = cfg_q.control_one_rate_mode[acr_pkg::CTRL1_FAST_READ_BIT];
  wire go_active = active & ~active_prev_q;

  logic [7:0] ptr_next;

  acr_ptr_step u_step (
    .ptr_i       (ptr_q),
    .fast_read_i (fast_read),
    .next_o      (ptr_next)
  );

  wire byte_done = (cnt_q == acr_pkg::BYTE_BITS);
  wire addr_hit  = (sr_q[7:1] == BUS_ADDR); // [RL11]
  wire wr_stb    = scl_fall & (st_q == acr_pkg::ST_WDATA) & byte_done;
  wire [7:0] wdata = sr_q;

  // Read decode
  function automatic logic [7:0] low_byte(input logic [acr_pkg::SAMPLE_W-1:0] s);
    return {s[1:0], acr_pkg::LOW_PAD}; // [RL3]
  endfunction : low_byte

  function automatic logic [7:0] high_byte(input logic [acr_pkg::SAMPLE_W-1:0] s);
    return s[acr_pkg::SAMPLE_W-1:2]; // [RL3]
  endfunction : high_byte

  logic [1:0] sys_mode;
  assign sys_mode = !active ? acr_pkg::MODE_STANDBY :
                    (sleep_i ? acr_pkg::MODE_SLEEP : acr_pkg::MODE_WAKE);

  logic [7:0] rd_byte;

  always_comb
  begin
    case (ptr_q)
      acr_pkg::ADDR_DATA_STATUS:   rd_byte = stat_q.data_status;
      acr_pkg::ADDR_X_HIGH:        rd_byte = high_byte(smp_q.x);
      acr_pkg::ADDR_X_LOW:         rd_byte = low_byte(smp_q.x);
      acr_pkg::ADDR_Y_HIGH:        rd_byte = high_byte(smp_q.y);
      acr_pkg::ADDR_Y_LOW:         rd_byte = low_byte(smp_q.y);
      acr_pkg::ADDR_Z_HIGH:        rd_byte = high_byte(smp_q.z);
      acr_pkg::ADDR_Z_LOW:         rd_byte = low_byte(smp_q.z);
      acr_pkg::ADDR_SYS_MODE:      rd_byte = {6'h00, sys_mode};
      acr_pkg::ADDR_EVENT_SOURCE:  rd_byte = stat_q.event_source;
      acr_pkg::ADDR_IDENTITY:      rd_byte = IDENTITY_VALUE;
      acr_pkg::ADDR_RANGE_CFG:     rd_byte = cfg_q.range_config;
      acr_pkg::ADDR_ORIENT_STATUS: rd_byte = stat_q.orientation_status;
      acr_pkg::ADDR_ORIENT_CFG:    rd_byte = cfg_q.orientation_config;
      acr_pkg::ADDR_ORIENT_DBNC:   rd_byte = cfg_q.orientation_debounce;
      acr_pkg::ADDR_BF_COMP:       rd_byte = acr_pkg::RST_BF_COMP; // [RL10]
      acr_pkg::ADDR_TRIP_ANGLE:    rd_byte = acr_pkg::RST_TRIP_ANGLE; // [RL10]
      acr_pkg::ADDR_MOTION_CFG:    rd_byte = cfg_q.motion_detect_config;
      acr_pkg::ADDR_MOTION_SOURCE: rd_byte = stat_q.motion_source;
      acr_pkg::ADDR_MOTION_THS:    rd_byte = cfg_q.motion_detect_threshold;
      acr_pkg::ADDR_MOTION_DBNC:   rd_byte = cfg_q.motion_detect_debounce;
      acr_pkg::ADDR_SLEEP_COUNT:   rd_byte = cfg_q.sleep_wake_counter;
      acr_pkg::ADDR_CTRL_ONE:      rd_byte = cfg_q.control_one_rate_mode;
      acr_pkg::ADDR_CTRL_TWO:      rd_byte = cfg_q.control_two_sleep_reset;
      acr_pkg::ADDR_CTRL_THREE:    rd_byte = cfg_q.control_three_wake_pin;
      acr_pkg::ADDR_CTRL_FOUR:     rd_byte = cfg_q.control_four_irq_enable;
      acr_pkg::ADDR_CTRL_FIVE:     rd_byte = cfg_q.control_five_irq_route;
      acr_pkg::ADDR_X_OFFSET:      rd_byte = cfg_q.x_offset_adjust;
      acr_pkg::ADDR_Y_OFFSET:      rd_byte = cfg_q.y_offset_adjust;
      acr_pkg::ADDR_Z_OFFSET:      rd_byte = cfg_q.z_offset_adjust;
      default:                     rd_byte = acr_pkg::RST_ZERO; // [RL4]
    endcase
  end

  // Bus engine: bits sampled on SCL rise, SDA changed on SCL fall
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sr_d   = sr_q;
    tx_d   = tx_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    oe_n_d = oe_n_q;
    if (bus_stop)
    begin
      st_d   = acr_pkg::ST_IDLE;
      oe_n_d = 1'b1;
    end
    else if (bus_start)
    begin
      // Repeated start keeps the pointer for random reads
      st_d   = acr_pkg::ST_ADDR;
      cnt_d  = 4'h0;
      oe_n_d = 1'b1;
    end
    else
    begin
      case (st_q)
        acr_pkg::ST_IDLE:
        begin
          oe_n_d = 1'b1;
        end
        acr_pkg::ST_ADDR, acr_pkg::ST_REG, acr_pkg::ST_WDATA:
        begin
          if (scl_rise && !byte_done)
          begin
            sr_d  = {sr_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            oe_n_d = 1'b0;
            cnt_d  = 4'h0;
            if (st_q == acr_pkg::ST_ADDR)
            begin
              rw_d = sr_q[0]; // [RL11]
              st_d = acr_pkg::ST_ACK_AD;
              if (!addr_hit)
              begin
                // Not ours: stay off the bus until the next start
                oe_n_d = 1'b1;
                st_d   = acr_pkg::ST_IDLE;
              end
            end
            else if (st_q == acr_pkg::ST_REG)
            begin
              ptr_d = sr_q;
              st_d  = acr_pkg::ST_ACK_RG;
            end
            else
            begin
              ptr_d = ptr_next; // [RL12] [RL14]
              st_d  = acr_pkg::ST_ACK_WR;
            end
          end
        end
        acr_pkg::ST_ACK_AD, acr_pkg::ST_ACK_RG, acr_pkg::ST_ACK_WR:
        begin
          if (scl_fall)
          begin
            oe_n_d = 1'b1;
            cnt_d  = 4'h0;
            if (st_q == acr_pkg::ST_ACK_AD && rw_q)
            begin
              tx_d   = rd_byte;
              oe_n_d = rd_byte[7];
              ptr_d  = ptr_next; // [RL12]
              st_d   = acr_pkg::ST_RDATA;
            end
            else if (st_q == acr_pkg::ST_ACK_AD)
              st_d = acr_pkg::ST_REG;
            else
              st_d = acr_pkg::ST_WDATA;
          end
        end
        acr_pkg::ST_RDATA:
        begin
          if (scl_rise)
            cnt_d = cnt_q + 4'h1;
          else if (scl_fall && byte_done)
          begin
            oe_n_d = 1'b1;
            st_d   = acr_pkg::ST_RACK;
          end
          else if (scl_fall)
          begin
            tx_d   = {tx_q[6:0], 1'b0};
            oe_n_d = tx_q[6];
          end
        end
        acr_pkg::ST_RACK:
        begin
          if (scl_rise && sda_s)
            st_d = acr_pkg::ST_IDLE; // [RL12]
          else if (scl_fall)
          begin
            cnt_d  = 4'h0;
            tx_d   = rd_byte;
            oe_n_d = rd_byte[7];
            ptr_d  = ptr_next; // [RL12]
            st_d   = acr_pkg::ST_RDATA;
          end
        end
        default:
        begin
          st_d   = acr_pkg::ST_IDLE;
          oe_n_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q   <= acr_pkg::ST_IDLE;
      cnt_q  <= 4'h0;
      sr_q   <= 8'h00;
      tx_q   <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sr_q   <= sr_d;
      tx_q   <= tx_d;
      ptr_q  <= ptr_d;
      rw_q   <= rw_d;
      oe_n_q <= oe_n_d;
    end
  end

  // Register writes
  wire soft_rst_d = wr_stb && (ptr_q == acr_pkg::ADDR_CTRL_TWO)
                    && wdata[acr_pkg::CTRL2_SOFT_RST_BIT];

  always_comb
  begin
    cfg_d = cfg_q;
    if (soft_rst_q)
      cfg_d = acr_pkg::CFG_RESET; // [RL10]
    else if (wr_stb && !active)
    begin
      case (ptr_q) // [RL9]
        acr_pkg::ADDR_RANGE_CFG:    cfg_d.range_config            = wdata;
        acr_pkg::ADDR_ORIENT_CFG:   cfg_d.orientation_config      = wdata;
        acr_pkg::ADDR_ORIENT_DBNC:  cfg_d.orientation_debounce    = wdata;
        acr_pkg::ADDR_MOTION_CFG:   cfg_d.motion_detect_config    = wdata;
        acr_pkg::ADDR_MOTION_THS:   cfg_d.motion_detect_threshold = wdata;
        acr_pkg::ADDR_MOTION_DBNC:  cfg_d.motion_detect_debounce  = wdata;
        acr_pkg::ADDR_SLEEP_COUNT:  cfg_d.sleep_wake_counter      = wdata;
        acr_pkg::ADDR_CTRL_ONE:     cfg_d.control_one_rate_mode   = wdata;
        acr_pkg::ADDR_CTRL_TWO:
        begin
          // Soft reset bit self-clears, it is never stored
          cfg_d.control_two_sleep_reset = wdata;
          cfg_d.control_two_sleep_reset[acr_pkg::CTRL2_SOFT_RST_BIT] = 1'b0;
        end
        acr_pkg::ADDR_CTRL_THREE:   cfg_d.control_three_wake_pin  = wdata;
        acr_pkg::ADDR_CTRL_FOUR:    cfg_d.control_four_irq_enable = wdata;
        acr_pkg::ADDR_CTRL_FIVE:    cfg_d.control_five_irq_route  = wdata;
        acr_pkg::ADDR_X_OFFSET:     cfg_d.x_offset_adjust         = wdata;
        acr_pkg::ADDR_Y_OFFSET:     cfg_d.y_offset_adjust         = wdata;
        acr_pkg::ADDR_Z_OFFSET:     cfg_d.z_offset_adjust         = wdata;
        default:                    cfg_d = cfg_q; // [RL14]
      endcase
    end
    else if (wr_stb && ptr_q == acr_pkg::ADDR_CTRL_ONE)
      cfg_d.control_one_rate_mode[acr_pkg::CTRL1_ACTIVE_BIT] =
        wdata[acr_pkg::CTRL1_ACTIVE_BIT]; // [RL9]
  end

  // Config holds across active to standby; only bus writes and reset touch it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_q         <= acr_pkg::CFG_RESET; // [RL10]
      soft_rst_q    <= 1'b0;
      active_prev_q <= 1'b0;
    end
    else
    begin
      cfg_q         <= cfg_d; // [RL8]
      soft_rst_q    <= soft_rst_d; // [RL9]
      active_prev_q <= active;
    end
  end

  // Samples and status: captured only while active; status alone cleared on wake
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      smp_q  <= '0;
      stat_q <= '0;
    end
    else if (soft_rst_q)
    begin
      smp_q  <= '0;
      stat_q <= '0;
    end
    else
    begin
      if (sample_load_i && active)
        smp_q <= sample_i; // [RL6]
      if (stat_load_i && active)
        stat_q <= stat_i; // [RL6]
      else if (go_active)
        stat_q <= '0; // [RL7]
    end
  end

  assign sda_o        = 1'b0;
  assign sda_oe_n     = oe_n_q;
  assign cfg_o        = cfg_q;
  assign active_o     = active;
  assign fast_read_o  = fast_read; // [RL13]
  assign soft_reset_o = soft_rst_q;

endmodule : acr_regbank

// ### dv/acr_regbank_asserts.sv
`timescale 1ns/1ps
module acr_regbank_chk (
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  // Bus pins
  input wire logic              scl_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_n,
  // Configuration
  input wire acr_pkg::acr_cfg_t cfg_o,
  input wire logic              active_o,
  input wire logic              fast_read_o,
  input wire logic              soft_reset_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  acr_pkg::acr_cfg_t cfg_m;
  logic [1:0]        age_q;
  // Active bit may be written at any time, so it is masked
  always_comb
  begin
    cfg_m = cfg_o;
    cfg_m.control_one_rate_mode[0] = 1'b0;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst) age_q <= 2'h0;
    else if (age_q != 2'h3) age_q <= age_q + 2'h1;
  end
  property p_drain; sda_o == 1'b0; endproperty
  a_drain: assert property (p_drain) else $error("data pin driven high");
  property p_oe_scl; $changed(sda_oe_n) |-> !$past(scl_i); endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data moved while clock high");
  // Writes land just after a byte ends, so the bus clock is low then
  property p_act; $changed(cfg_o) |-> $past(soft_reset_o) || !$past(scl_i); endproperty
  a_act: assert property (p_act) else $error("config moved outside a byte end");
  property p_fast; $changed(fast_read_o) |-> !$past(active_o) || $past(soft_reset_o); endproperty
  a_fast: assert property (p_fast) else $error("fast read changed while active");
  property p_frozen; $past(active_o) && !$past(soft_reset_o) |-> $stable(cfg_m); endproperty
  a_frozen: assert property (p_frozen) else $error("config changed while active");
  property p_pulse; soft_reset_o |=> !soft_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("soft reset pulse too long");
  property p_soft; soft_reset_o |=> cfg_o == acr_pkg::CFG_RESET && !active_o; endproperty
  a_soft: assert property (p_soft) else $error("soft reset left config");
  property p_boot; age_q != 2'h3 |-> cfg_o == acr_pkg::CFG_RESET && sda_oe_n; endproperty
  a_boot: assert property (p_boot) else $error("wrong values after reset");
  c_ack: cover property ($fell(sda_oe_n));
  c_soft: cover property (soft_reset_o);
  c_wake: cover property ($rose(active_o));
endmodule : acr_regbank_chk
bind acr_regbank acr_regbank_chk u_chk (.clk(clk), .sys_rst(sys_rst), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg_o(cfg_o), .active_o(active_o),
  .fast_read_o(fast_read_o), .soft_reset_o(soft_reset_o));

// ### dv/acr_bus_master.sv
`timescale 1ns/1ps
module acr_bus_master (
  // Clock
  input  wire logic clk,
  // Bus pins
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic sda_m;
  int   hp = 8;
  // Pull-up: line is low when either side pulls
  assign sda = sda_m & sda_oe_n;
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic half();
    repeat (hp) @(negedge clk);
  endtask : half
  // Also serves as repeated start
  task automatic start();
    sda_m = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b0;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_m = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_m = 1'b1;
    half();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    half();
    scl = 1'b1;
    repeat (4) @(negedge clk);
    r = sda;
    half();
    scl = 1'b0;
  endtask : bit_io
  // Ninth bit: a = 1 releases the line (NAK), a = 0 acknowledges
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ak);
  endtask : byte_io
endmodule : acr_bus_master

// ### dv/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  // Arbitrary identity value
  localparam logic [7:0] ID = 8'h3c;
  logic                 clk, sys_rst, scl, sda, sda_oe_n, sleep_i;
  logic                 sample_load_i, stat_load_i, active_o, fast_read_o, soft_reset_o;
  acr_pkg::acr_sample_t sample_i;
  acr_pkg::acr_stat_t   stat_i;
  acr_pkg::acr_cfg_t    cfg_o;
  int                   bad_count = 0;
  int                   samples_checked = 0;
  acr_regbank #(.IDENTITY_VALUE(ID)) uut (.clk(clk), .sys_rst(sys_rst), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n), .sample_i(sample_i),
    .sample_load_i(sample_load_i), .stat_i(stat_i), .stat_load_i(stat_load_i),
    .sleep_i(sleep_i), .cfg_o(cfg_o), .active_o(active_o), .fast_read_o(fast_read_o),
    .soft_reset_o(soft_reset_o));
  acr_bus_master mst (.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$], input logic [7:0] dev = 8'h3a);
    logic [7:0] q;
    logic       ak;
    logic       e;
    e = (dev != 8'h3a);
    mst.start();
    mst.byte_io(dev, 1'b1, q, ak);
    `CHK("addr ack", e, ak)
    mst.byte_io(a, 1'b1, q, ak);
    foreach (d[i])
    begin
      mst.byte_io(d[i], 1'b1, q, ak);
      `CHK("data ack", e, ak)
    end
    mst.stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
    logic [7:0] b;
    logic       ak;
    q = {};
    mst.start();
    mst.byte_io(8'h3a, 1'b1, b, ak);
    mst.byte_io(a, 1'b1, b, ak);
    mst.start();
    mst.byte_io(8'h3b, 1'b1, b, ak);
    `CHK("read ack", 1'b0, ak)
    for (int i = 0; i < n; i++)
    begin
      mst.byte_io(8'hff, i == n - 1, b, ak);
      q.push_back(b);
    end
    mst.stop();
  endtask : rd
  task automatic cmp(input string n, input logic [7:0] q[$], input logic [7:0] e[$]);
    foreach (e[i]) `CHK(n, e[i], q[i])
  endtask : cmp
  task automatic load(input acr_pkg::acr_sample_t s, input acr_pkg::acr_stat_t t);
    @(negedge clk);
    sample_i = s;
    stat_i = t;
    sample_load_i = 1'b1;
    stat_load_i = 1'b1;
    @(negedge clk);
    sample_load_i = 1'b0;
    stat_load_i = 1'b0;
  endtask : load
  function automatic logic [7:0] rst_val(input logic [7:0] a);
    case (a)
      8'h0d: return ID;
      8'h11: return 8'h80;
      8'h13: return 8'h44;
      8'h14: return 8'h84;
      default: return 8'h00;
    endcase
  endfunction : rst_val
  task automatic t_boot();
    logic [7:0] q[$];
    logic [7:0] e[$];
    for (int i = 7; i <= 8'h31; i++) e.push_back(rst_val(8'(i)));
    e.push_back(ID);
    e.push_back(8'h00);
    rd(8'h07, 45, q);
    cmp("reset map", q, e);
    $display("test boot done");
  endtask : t_boot
  task automatic t_wrap();
    logic [7:0] q[$];
    mst.hp = 20;
    wr(8'h30, {8'ha5, 8'h5a, 8'h11, 8'h22, 8'h33});
    mst.hp = 8;
    `CHK("y offset", 8'ha5, cfg_o.y_offset_adjust)
    `CHK("range", 8'h22, cfg_o.range_config)
    rd(8'h30, 5, q);
    cmp("wrap", q, {8'ha5, 8'h5a, ID, 8'h22, 8'h00});
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_active();
    logic [7:0] q[$];
    wr(8'h2a, {8'h01});
    `CHK("active", 1'b1, active_o)
    load({10'h2d5, 10'h13a, 10'h3c3}, 32'h81422096);
    rd(8'h00, 8, q);
    cmp("burst", q, {8'h81, 8'hb5, 8'h40, 8'h4e, 8'h80, 8'hf0, 8'hc0, 8'h81});
    sleep_i = 1'b1;
    rd(8'h0b, 2, q);
    cmp("mode", q, {8'h02, 8'h42});
    wr(8'h0e, {8'h03});
    `CHK("range locked", 8'h22, cfg_o.range_config)
    $display("test active done");
  endtask : t_active
  task automatic t_fast();
    logic [7:0] q[$];
    sleep_i = 1'b0;
    wr(8'h2a, {8'h00});
    `CHK("kept range", 8'h22, cfg_o.range_config)
    `CHK("kept offset", 8'h5a, cfg_o.z_offset_adjust)
    wr(8'h2a, {8'h02});
    `CHK("fast", 1'b1, fast_read_o)
    wr(8'h2a, {8'h03});
    rd(8'h00, 1, q);
    `CHK("status cleared", 8'h00, q[0])
    rd(8'h0b, 2, q);
    cmp("wake", q, {8'h01, 8'h00});
    load({10'h3ff, 10'h001, 10'h200}, 32'h0f000000);
    rd(8'h01, 4, q);
    cmp("fast burst", q, {8'hff, 8'h00, 8'h80, 8'h0f});
    wr(8'h2b, {8'h40});
    `CHK("soft cfg", acr_pkg::CFG_RESET, cfg_o)
    `CHK("soft active", 1'b0, active_o)
    $display("test fast done");
  endtask : t_fast
  task automatic t_addr();
    wr(8'h0e, {8'h01}, 8'h3c);
    `CHK("foreign write", 8'h00, cfg_o.range_config)
    $display("test addr done");
  endtask : t_addr
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    sys_rst = 1'b1;
    sleep_i = 1'b0;
    sample_i = '0;
    stat_i = '0;
    sample_load_i = 1'b0;
    stat_load_i = 1'b0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_boot();
    t_wrap();
    t_active();
    t_fast();
    t_addr();
    tally_and_finish();
  end
  // About three and a half times the expected run
  initial
  begin
    repeat (80000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb
